/* rtl/ccsr_regs.sv */
// Configuration and status register set behind the 16-bit command port.
`timescale 1ns/10ps
module ccsr_regs
  import ccsr_pkg::*;
(
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RSTN,
  input  wire logic              I_E_N,
  input  wire logic              I_W_N,
  input  wire logic              I_CM_N,
  input  wire logic [DQ_W-1:0]   I_DQ,
  output logic      [DQ_W-1:0]   O_DQ,
  output logic                   O_DQ_OE,
  input  wire logic [NF_W-1:0]   I_NEXT_FREE,
  input  wire logic              I_ARRAY_FULL_N,
  input  wire logic              I_MULTI_HIT_N,
  input  wire logic [1:0]        I_VALIDITY_CODE,
  input  wire logic [NF_W-1:0]   I_HIT_LOCATION,
  input  wire logic              I_HIT_FLAG_N,
  input  wire logic [3:0]        I_STICKY_SOURCE,
  output logic      [2:0]        O_PARTITION,
  output logic      [1:0]        O_MASK_SEL,
  output logic      [1:0]        O_STEP_MODE,
  output logic      [1:0]        O_DEST_START_LIMIT,
  output logic      [1:0]        O_DEST_END_LIMIT,
  output logic      [1:0]        O_SRC_START_LIMIT,
  output logic      [1:0]        O_SRC_END_LIMIT,
  output logic      [1:0]        O_DEST_COUNT,
  output logic      [1:0]        O_SRC_COUNT,
  output logic                   O_SOFT_RESET
);

  function automatic logic [1:0] fld2(input logic [DQ_W-1:0] d, input int lsb);
    fld2 = d[lsb+:2];
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [PIN_W-1:0] pin_s1_next, pin_s2_next, pin_s3_next;
  logic             e_lvl_reg, e_lvl_next;

  always_comb begin
    pin_s1_next = {I_E_N, I_W_N, I_CM_N, I_DQ};
    pin_s2_next = pin_s1_reg;
    pin_s3_next = pin_s2_reg;
    e_lvl_next  = e_lvl_reg;
    if (pin_s2_reg[PIN_W-1] == pin_s3_reg[PIN_W-1]) begin
      e_lvl_next = pin_s3_reg[PIN_W-1];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      pin_s3_reg <= '1;
      e_lvl_reg  <= 1'b1;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
      pin_s3_reg <= pin_s3_next;
      e_lvl_reg  <= e_lvl_next;
    end
  end

  // A cycle begins when chip enable has settled low; it ends when it settles high.
  logic            cyc_start, cyc_end, is_cmd, is_wr, cmd_wr, cmd_rd;
  logic [DQ_W-1:0] din;
  assign cyc_start = e_lvl_reg & ~e_lvl_next;
  assign cyc_end   = ~e_lvl_reg & e_lvl_next;
  assign is_wr     = ~pin_s3_reg[PIN_W-2];
  assign is_cmd    = ~pin_s3_reg[PIN_W-3];
  assign din       = pin_s3_reg[DQ_W-1:0];
  assign cmd_wr    = cyc_start & is_cmd & is_wr;
  assign cmd_rd    = cyc_start & is_cmd & ~is_wr;

  // ==========================================================================
  // Read-only words
  logic [31:0]     stat_word;
  logic [DQ_W-1:0] nf_word, src_word;
  logic [NF_W-1:0] hit_loc;

  assign hit_loc   = LARGE_PART ? I_HIT_LOCATION : {1'b0, I_HIT_LOCATION[NF_W-2:0]};
  assign stat_word = {I_ARRAY_FULL_N, I_MULTI_HIT_N,
                      I_VALIDITY_CODE,
                      18'h0, hit_loc, I_HIT_FLAG_N};
  assign nf_word   = LARGE_PART ? {7'h0, I_NEXT_FREE}
                                : {8'h0, I_NEXT_FREE[NF_W-2:0]};
  assign src_word  = {PART_IDENT, I_STICKY_SOURCE};

  // ==========================================================================
  // Command sequencing and registers
  ccsr_pend_t      pend_reg, pend_next;
  logic [2:0]      part_reg, part_next;
  logic [1:0]      mask_reg, mask_next, step_reg, step_next;
  logic [1:0]      dst_reg, dst_next, dend_reg, dend_next;
  logic [1:0]      sst_reg, sst_next, send_reg, send_next;
  logic [1:0]      dcnt_reg, dcnt_next, scnt_reg, scnt_next;
  logic [DQ_W-1:0] dq_reg, dq_next;
  logic            oe_reg, oe_next, srst_reg, srst_next;
  logic [DQ_W-1:0] ct_word, sc_word;

  assign ct_word = {1'b0, 6'h0, part_reg, mask_reg, step_reg, 2'h0};
  assign sc_word = {1'b0, dst_reg, dend_reg, 1'b0, sst_reg, send_reg,
                    1'b0, dcnt_reg, 1'b0, scnt_reg};

  always_comb begin
    pend_next = pend_reg;
    part_next = part_reg;
    mask_next = mask_reg;
    step_next = step_reg;
    dst_next  = dst_reg;
    dend_next = dend_reg;
    sst_next  = sst_reg;
    send_next = send_reg;
    dcnt_next = dcnt_reg;
    scnt_next = scnt_reg;
    dq_next   = dq_reg;
    oe_next   = oe_reg;
    srst_next = 1'b0;
    if (cyc_end) begin
      oe_next = 1'b0;
    end
    if (cmd_rd) begin
      oe_next   = 1'b1;
      pend_next = PEND_IDLE;
      case (pend_reg)
        PEND_STAT_HI: dq_next = stat_word[31:16];
        PEND_CT:      dq_next = ct_word;
        PEND_SC:      dq_next = sc_word;
        PEND_NF:      dq_next = nf_word;
        PEND_SRC:     dq_next = src_word;
        default: begin
          dq_next   = stat_word[15:0];
          pend_next = PEND_STAT_HI;
        end
      endcase
    end else if (cmd_wr) begin
      pend_next = PEND_IDLE;
      if (pend_reg == PEND_CT) begin
        if (!din[CT_RST_BIT]) begin
          // The whole register set returns to defaults; other bits of this word are void.
          srst_next = 1'b1;
          part_next = PART_RST;
          mask_next = MASK_RST;
          step_next = STEP_RST;
          dst_next  = LIM_START_RST;
          dend_next = LIM_END_RST;
          sst_next  = LIM_START_RST;
          send_next = LIM_END_RST;
          dcnt_next = COUNT_RST;
          scnt_next = COUNT_RST;
        end else begin
          if (din[CT_PART_LSB+:3] != PART_KEEP) begin
            part_next = din[CT_PART_LSB+:3];
          end
          if (fld2(din, CT_MASK_LSB) != MASK_KEEP) begin
            mask_next = fld2(din, CT_MASK_LSB);
          end
          if (fld2(din, CT_STEP_LSB) != STEP_KEEP) begin
            step_next = fld2(din, CT_STEP_LSB);
          end
        end
      end else if (pend_reg == PEND_SC) begin
        if (!din[SC_DLIM_BIT]) begin
          dst_next  = fld2(din, SC_DST_LSB);
          dend_next = fld2(din, SC_DEND_LSB);
        end
        if (!din[SC_SLIM_BIT]) begin
          sst_next  = fld2(din, SC_SST_LSB);
          send_next = fld2(din, SC_SEND_LSB);
        end
        if (!din[SC_DCNT_BIT]) begin
          dcnt_next = fld2(din, SC_DCV_LSB);
        end
        if (!din[SC_SCNT_BIT]) begin
          scnt_next = fld2(din, SC_SCV_LSB);
        end
      end else if (din == OP_XFER_CT) begin
        pend_next = PEND_CT;
      end else if (din == OP_XFER_SC) begin
        pend_next = PEND_SC;
      end else if (din == OP_XFER_NF) begin
        pend_next = PEND_NF;
      end else if (din == OP_XFER_SRC) begin
        pend_next = PEND_SRC;
      end
    end else if (cyc_start) begin
      // Any data cycle breaks a pending transfer or a status pair.
      pend_next = PEND_IDLE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      pend_reg <= PEND_IDLE;
      part_reg <= PART_RST;
      mask_reg <= MASK_RST;
      step_reg <= STEP_RST;
      dst_reg  <= LIM_START_RST;
      dend_reg <= LIM_END_RST;
      sst_reg  <= LIM_START_RST;
      send_reg <= LIM_END_RST;
      dcnt_reg <= COUNT_RST;
      scnt_reg <= COUNT_RST;
      dq_reg   <= 16'h0000;
      oe_reg   <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      part_reg <= part_next;
      mask_reg <= mask_next;
      step_reg <= step_next;
      dst_reg  <= dst_next;
      dend_reg <= dend_next;
      sst_reg  <= sst_next;
      send_reg <= send_next;
      dcnt_reg <= dcnt_next;
      scnt_reg <= scnt_next;
      dq_reg   <= dq_next;
      oe_reg   <= oe_next;
      srst_reg <= srst_next;
    end
  end

  assign O_DQ               = dq_reg;
  assign O_DQ_OE            = oe_reg;
  assign O_PARTITION        = part_reg;
  assign O_MASK_SEL         = mask_reg;
  assign O_STEP_MODE        = step_reg;
  assign O_DEST_START_LIMIT = dst_reg;
  assign O_DEST_END_LIMIT   = dend_reg;
  assign O_SRC_START_LIMIT  = sst_reg;
  assign O_SRC_END_LIMIT    = send_reg;
  assign O_DEST_COUNT       = dcnt_reg;
  assign O_SRC_COUNT        = scnt_reg;
  assign O_SOFT_RESET       = srst_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_ct_write;
    cmd_wr && pend_reg == PEND_CT;
  endsequence
  sequence s_sc_write;
    cmd_wr && pend_reg == PEND_SC;
  endsequence

  a_rst_clears_all: assert property (s_ct_write and din[CT_RST_BIT] == 1'b0 |=>
    O_SOFT_RESET && part_reg == PART_RST && dend_reg == LIM_END_RST ##1 !O_SOFT_RESET)
    else $error("Control reset did not restore defaults.");
  a_ct_readback: assert property (cmd_rd && pend_reg == PEND_CT |=>
    dq_reg[15:9] == 7'h0 && dq_reg[8:6] == part_reg && O_DQ_OE)
    else $error("Control read back wrong.");
  a_part_keep: assert property (s_ct_write and din[15] && din[8:6] == 3'h7
    |=> $stable(part_reg)) else $error("Partition changed on keep code.");
  a_mask_load: assert property (s_ct_write and din[15] && din[5:4] != 2'h3
    |=> mask_reg == $past(din[5:4])) else $error("Mask select not loaded.");
  a_step_keep: assert property (s_ct_write and din[15] && din[3:2] == 2'h3
    |=> $stable(step_reg)) else $error("Stepping changed on keep code.");
  a_dest_limits: assert property (s_sc_write and !din[15] |=>
    dst_reg == $past(din[14:13]) && dend_reg == $past(din[12:11]))
    else $error("Destination limits not loaded.");
  a_src_limit_keep: assert property (s_sc_write and din[10] |=>
    $stable(sst_reg) && $stable(send_reg)) else $error("Source limits changed.");
  a_dest_count: assert property (s_sc_write and !din[5] |=>
    dcnt_reg == $past(din[4:3])) else $error("Destination count not loaded.");
  a_src_count: assert property (s_sc_write and din[2] |=>
    $stable(scnt_reg)) else $error("Source count changed.");
  a_seg_strobes: assert property (cmd_rd && pend_reg == PEND_SC |=>
    !dq_reg[15] && !dq_reg[10] && !dq_reg[5] && !dq_reg[2])
    else $error("Segment strobe bit read as one.");
  a_nf_read: assert property (cmd_rd && pend_reg == PEND_NF |=>
    dq_reg == {7'h0, $past(I_NEXT_FREE)}) else $error("Free pointer read wrong.");
  a_stat_pair: assert property (cmd_rd && pend_reg == PEND_IDLE |=>
    dq_reg == $past(stat_word[15:0]) && pend_reg == PEND_STAT_HI)
    else $error("Status low half wrong.");
  a_stat_high: assert property (cmd_rd && pend_reg == PEND_STAT_HI |=>
    dq_reg[15] == $past(I_ARRAY_FULL_N) && dq_reg[14] == $past(I_MULTI_HIT_N)
    && dq_reg[13:12] == $past(I_VALIDITY_CODE) && dq_reg[11:0] == 12'h0)
    else $error("Status high half wrong.");
  a_src_read: assert property (cmd_rd && pend_reg == PEND_SRC |=>
    dq_reg == {PART_IDENT, $past(I_STICKY_SOURCE)}) else $error("Ident word wrong.");
endmodule

/* common/ccsr_pkg.sv */
// Constants, field positions and types of the CAM configuration and status registers.
package ccsr_pkg;
  // ==========================================================================
  // Pin and part constants
  localparam int         DQ_W        = 16;
  localparam int         PIN_W       = DQ_W + 3;
  localparam int         NF_W        = 9;
  localparam logic       LARGE_PART  = 1'b1;
  // Identification value is arbitrary.
  localparam logic [11:0] PART_IDENT = 12'h5a3;

  // ==========================================================================
  // Instruction codes for transfers to or from a register
  localparam logic [15:0] OP_XFER_CT  = 16'h0200;
  localparam logic [15:0] OP_XFER_SC  = 16'h0201;
  localparam logic [15:0] OP_XFER_NF  = 16'h0202;
  localparam logic [15:0] OP_XFER_SRC = 16'h0203;

  // ==========================================================================
  // Control register fields
  localparam int         CT_RST_BIT  = 15;
  localparam int         CT_PART_LSB = 6;
  localparam int         CT_MASK_LSB = 4;
  localparam int         CT_STEP_LSB = 2;
  localparam logic [2:0] PART_KEEP   = 3'h7;
  localparam logic [1:0] MASK_KEEP   = 2'h3;
  localparam logic [1:0] STEP_KEEP   = 2'h3;
  localparam logic [2:0] PART_RST    = 3'h0;
  localparam logic [1:0] MASK_RST    = 2'h0;
  localparam logic [1:0] STEP_RST    = 2'h0;

  // ==========================================================================
  // Segment control fields
  localparam int         SC_DLIM_BIT = 15;
  localparam int         SC_DST_LSB  = 13;
  localparam int         SC_DEND_LSB = 11;
  localparam int         SC_SLIM_BIT = 10;
  localparam int         SC_SST_LSB  = 8;
  localparam int         SC_SEND_LSB = 6;
  localparam int         SC_DCNT_BIT = 5;
  localparam int         SC_DCV_LSB  = 3;
  localparam int         SC_SCNT_BIT = 2;
  localparam int         SC_SCV_LSB  = 0;
  localparam logic [1:0] LIM_START_RST = 2'h0;
  localparam logic [1:0] LIM_END_RST   = 2'h3;
  localparam logic [1:0] COUNT_RST     = 2'h0;

  // ==========================================================================
  // Command sequencing state
  typedef enum logic [2:0] {
    PEND_IDLE, PEND_STAT_HI, PEND_CT, PEND_SC, PEND_NF, PEND_SRC
  } ccsr_pend_t;
endpackage

/* dv/ccsr_host.sv */
// Host model that runs command and data cycles on the register port.
`timescale 1ns/10ps
module ccsr_host (
  input  wire logic        I_REF_CLK,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_dq_oe,
  output logic             o_e_n,
  output logic             o_w_n,
  output logic             o_cm_n,
  output logic      [15:0] o_dq
);
  // ==========================================================================
  // Idle levels
  initial begin
    o_e_n  = 1'b1;
    o_w_n  = 1'b1;
    o_cm_n = 1'b1;
    o_dq   = 16'h0000;
  end

  // ==========================================================================
  // One cycle, entered just after a rising edge.
  // Controls settle a cycle before enable falls and hold well past the input filter.
  // The data lines are inverted when released so a stale value never looks valid.
  task automatic access(input logic cm_n, input logic w_n, input logic [15:0] wd,
                        output logic [15:0] rd, output bit ok);
    o_cm_n <= cm_n;
    o_w_n  <= w_n;
    o_dq   <= w_n ? ~o_dq : wd;
    @(posedge I_REF_CLK);
    o_e_n <= 1'b0;
    repeat (6) @(posedge I_REF_CLK);
    rd = i_dq;
    ok = (i_dq_oe === w_n);
    o_e_n <= 1'b1;
    o_dq  <= ~o_dq;
    repeat (5) @(posedge I_REF_CLK);
    ok = ok && (i_dq_oe === 1'b0);
  endtask
endmodule

/* dv/ccsr_regs_tb_top.sv */
// Self-checking bench for the CAM configuration and status registers.
`timescale 1ns/10ps
module ccsr_regs_tb_top
  import ccsr_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        e_n, w_n, cm_n, dq_oe, soft_rst;
  logic [15:0] host_dq, dev_dq, dq_pin;
  logic [8:0]  next_free = 9'h000;
  logic [8:0]  hit_loc = 9'h000;
  logic        full_n = 1'b1;
  logic        multi_n = 1'b1;
  logic        hit_n = 1'b1;
  logic [1:0]  vcode = 2'h0;
  logic [3:0]  sticky = 4'h0;
  logic [2:0]  part;
  logic [1:0]  mask, step, dsl, del, sst, sel, dcnt, scnt;
  logic [18:0] sets;
  int          err_count = 0;
  int          checks_done = 0;
  int          pulses = 0;

  always #4 clk = ~clk;
  assign dq_pin = dq_oe ? dev_dq : host_dq;
  assign sets = {part, mask, step, dsl, del, sst, sel, dcnt, scnt};
  always @(posedge clk) begin
    if (soft_rst === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  ccsr_host ccsr_host_i (.I_REF_CLK(clk), .i_dq(dq_pin), .i_dq_oe(dq_oe), .o_e_n(e_n),
    .o_w_n(w_n), .o_cm_n(cm_n), .o_dq(host_dq));
  ccsr_regs ccsr_regs_i (.I_REF_CLK(clk), .I_RSTN(rstn), .I_E_N(e_n), .I_W_N(w_n),
    .I_CM_N(cm_n), .I_DQ(dq_pin), .O_DQ(dev_dq), .O_DQ_OE(dq_oe), .I_NEXT_FREE(next_free),
    .I_ARRAY_FULL_N(full_n), .I_MULTI_HIT_N(multi_n), .I_VALIDITY_CODE(vcode),
    .I_HIT_LOCATION(hit_loc), .I_HIT_FLAG_N(hit_n), .I_STICKY_SOURCE(sticky),
    .O_PARTITION(part), .O_MASK_SEL(mask), .O_STEP_MODE(step), .O_DEST_START_LIMIT(dsl),
    .O_DEST_END_LIMIT(del), .O_SRC_START_LIMIT(sst), .O_SRC_END_LIMIT(sel),
    .O_DEST_COUNT(dcnt), .O_SRC_COUNT(scnt), .O_SOFT_RESET(soft_rst));

  // ==========================================================================
  // Compare and access tasks
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_set(input string what, input logic [18:0] exp);
    checks_done++;
    if (sets !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, sets);
    end
  endtask

  task automatic cyc(input logic cm, input logic wr, input logic [15:0] wd,
                     output logic [15:0] rd);
    bit ok;
    ccsr_host_i.access(cm, wr, wd, rd, ok);
    chk_word("output enable", 16'h0001, {15'h0000, ok});
  endtask

  task automatic reg_wr(input logic [15:0] op, input logic [15:0] d);
    logic [15:0] r;
    cyc(1'b0, 1'b0, op, r);
    cyc(1'b0, 1'b0, d, r);
  endtask

  task automatic reg_rd(input logic [15:0] op, output logic [15:0] r);
    cyc(1'b0, 1'b0, op, r);
    cyc(1'b0, 1'b1, 16'h0000, r);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    logic [15:0] r;
    logic [2:0]  p;
    logic [1:0]  m, s;
    logic [11:0] seg;
    logic [11:0] clr [4];
    clr = '{12'h0ff, 12'hf0f, 12'hff3, 12'hffc};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk_set("reset settings", {3'h0, 4'h0, 8'h33, 4'h0});
    // Reserved bits are written as ones to prove they read back as zeros.
    for (int i = 0; i < 7; i++) begin
      p = 3'(i);
      m = 2'(i % 3);
      s = 2'((i + 1) % 3);
      reg_wr(OP_XFER_CT, {1'b1, 6'h3f, p, m, s, 2'h3});
      chk_set("control fields", {p, m, s, 8'h33, 4'h0});
      reg_rd(OP_XFER_CT, r);
      chk_word("control readback", {7'h00, p, m, s, 2'h0}, r);
    end
    reg_wr(OP_XFER_CT, {1'b1, 6'h00, 3'h7, 2'h2, 2'h2, 2'h0});
    chk_set("partition kept", {3'h6, 2'h2, 2'h2, 8'h33, 4'h0});
    reg_wr(OP_XFER_CT, {1'b1, 6'h00, 3'h7, 2'h3, 2'h3, 2'h0});
    chk_set("all kept", {3'h6, 2'h2, 2'h2, 8'h33, 4'h0});
    reg_wr(OP_XFER_SC, 16'h3351);
    chk_set("segment load", {7'h6a, 12'h6d9});
    reg_wr(OP_XFER_SC, 16'hccae);
    chk_set("segment kept", {7'h6a, 12'h6d9});
    seg = 12'h6d9;
    for (int k = 0; k < 4; k++) begin
      reg_wr(OP_XFER_SC, 16'h8424 & ~(16'h8000 >> (k == 0 ? 0 : k == 1 ? 5 : k == 2 ? 10 : 13)));
      seg = seg & clr[k];
      chk_set("segment strobe", {7'h6a, seg});
      reg_rd(OP_XFER_SC, r);
      chk_word("segment readback",
               {1'b0, seg[11:8], 1'b0, seg[7:4], 1'b0, seg[3:2], 1'b0, seg[1:0]}, r);
    end
    next_free <= 9'h1a5;
    reg_rd(OP_XFER_NF, r);
    chk_word("free pointer", 16'h01a5, r);
    for (int v = 0; v < 4; v++) begin
      vcode   <= 2'(v);
      full_n  <= v[0];
      multi_n <= v[1];
      hit_n   <= ~v[0];
      hit_loc <= {v[1:0], 7'h2b};
      cyc(1'b0, 1'b1, 16'h0000, r);
      chk_word("status low", {6'h00, v[1:0], 7'h2b, ~v[0]}, r);
      cyc(1'b1, 1'b0, 16'h1234, r);
      cyc(1'b0, 1'b1, 16'h0000, r);
      chk_word("status low again", {6'h00, v[1:0], 7'h2b, ~v[0]}, r);
      cyc(1'b0, 1'b1, 16'h0000, r);
      chk_word("status high", {v[0], v[1], v[1:0], 12'h000}, r);
    end
    sticky <= 4'ha;
    reg_rd(OP_XFER_SRC, r);
    chk_word("ident and source", {PART_IDENT, 4'ha}, r);
    // A cleared top bit resets even though the other bits ask to keep the partition and mask select.
    reg_wr(OP_XFER_CT, 16'h7ff0);
    chk_set("soft reset settings", {3'h0, 4'h0, 8'h33, 4'h0});
    chk_word("soft reset pulses", 16'h0001, pulses[15:0]);
    reg_rd(OP_XFER_CT, r);
    chk_word("control after reset", 16'h0000, r);
    wrap_up();
  end
endmodule
